//--- rtl/occ_channel.sv
// Purpose: output compare channel with AXI4-Lite registers
// Assumes: time base counts and rollover pulses on clock_i
// Notes:   pin change registered one edge after the match
`timescale 1ns/1ps
`default_nettype none
module occ_channel #(
    parameter int unsigned CHAN_INDEX = 1,
    parameter int unsigned CNT_W      = 16
) (
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic [occ_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                      s_axi_awvalid_i,
    output logic                           s_axi_awready_o,
    input  wire logic [occ_pkg::DATA_W-1:0] s_axi_wdata_i,
    input  wire logic [3:0]                s_axi_wstrb_i,
    input  wire logic                      s_axi_wvalid_i,
    output logic                           s_axi_wready_o,
    output logic [1:0]                     s_axi_bresp_o,
    output logic                           s_axi_bvalid_o,
    input  wire logic                      s_axi_bready_i,
    input  wire logic [occ_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                      s_axi_arvalid_i,
    output logic                           s_axi_arready_o,
    output logic [occ_pkg::DATA_W-1:0]     s_axi_rdata_o,
    output logic [1:0]                     s_axi_rresp_o,
    output logic                           s_axi_rvalid_o,
    input  wire logic                      s_axi_rready_i,
    input  wire logic [CNT_W-1:0]          first_time_base_i,
    input  wire logic [CNT_W-1:0]          second_time_base_i,
    input  wire logic                      first_rollover_i,
    input  wire logic                      second_rollover_i,
    input  wire logic                      cpu_idle_i,
    input  wire logic                      gpio_level_i,
    input  wire logic                      fault_input_pin_n_i,
    output logic                           compare_output_pin_o,
    output logic                           irq_o,
    output logic                           dma_req_o
);
    import occ_pkg::*;

    localparam logic DMA_OK = (CHAN_INDEX == 1) || (CHAN_INDEX == 2);

    logic [15:0]        ctrl_r;
    logic [CNT_W-1:0]   prim_r;
    logic [CNT_W-1:0]   sec_r;
    logic [IRQ_W-1:0]   stat_r;
    logic [IRQ_W-1:0]   mask_r;
    logic               fault_flag_r;
    logic [2:0]         mode_prev_r;
    logic               pin_r;
    logic               pin_nxt;
    logic               done_r;
    logic               fault_prev_r;
    logic               dma_r;
    logic               aw_hold_r;
    logic               w_hold_r;
    logic [ADDR_W-1:0]  awaddr_r;
    logic [DATA_W-1:0]  wdata_r;
    logic [3:0]         wstrb_r;
    logic               bvalid_r;
    logic [1:0]         bresp_r;
    logic               rvalid_r;
    logic [DATA_W-1:0]  rdata_r;
    logic [1:0]         rresp_r;
    logic [2:0]         mode;
    logic               tb_sel;
    logic               halt;
    logic               entry;
    logic [CNT_W-1:0]   count_sel;
    logic               rollover;
    logic [1:0]         match;
    logic [CNT_W-1:0]   cmp_vals [2];
    logic               fault_s;
    logic               fault_act;
    logic               fault_fall;
    logic               edge_evt;
    logic               do_wr;
    logic               wr_hit;
    logic [15:0]        ctrl_rd;
    logic [IRQ_W-1:0]   stat_set;

    // control fields
    assign mode   = ctrl_r[MODE_LSB +: MODE_W];
    assign tb_sel = ctrl_r[TBSEL_BIT];
    assign halt   = ctrl_r[IDLE_BIT] & cpu_idle_i;
    assign entry  = (mode != mode_prev_r);

    // time base selection
    assign count_sel = tb_sel ? second_time_base_i : first_time_base_i;
    assign rollover  = tb_sel ? second_rollover_i : first_rollover_i;

    // compare against both values
    assign cmp_vals[0] = prim_r;
    assign cmp_vals[1] = sec_r;
    occ_match #(.CNT_W(CNT_W), .N(2)) u_match (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .count_i (count_sel),
        .cmp_i   (cmp_vals),
        .match_o (match)
    );

    // fault pin synchroniser, low means fault
    occ_sync #(.RST_VAL(1'b1)) u_fault_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (fault_input_pin_n_i),
        .sync_o  (fault_s)
    );
    assign fault_act  = ~fault_s;
    assign fault_fall = fault_prev_r & ~fault_s;

    // next pin level per mode
    always_comb begin
        pin_nxt = pin_r;
        if (mode == MODE_OFF) begin
            pin_nxt = gpio_level_i;
        end else if (entry) begin
            unique case (mode)
                MODE_HIGH:             pin_nxt = 1'b0;
                MODE_LOW:              pin_nxt = 1'b1;
                MODE_TOGGLE:           pin_nxt = pin_r;
                MODE_SINGLE, MODE_TRAIN: pin_nxt = 1'b0;
                default: pin_nxt = (prim_r != CMP_RST) && !(mode[0] && fault_act);
            endcase
        end else if (!halt) begin
            unique case (mode)
                MODE_HIGH:   if (match[0]) pin_nxt = 1'b1;
                MODE_LOW:    if (match[0]) pin_nxt = 1'b0;
                MODE_TOGGLE: if (match[0]) pin_nxt = ~pin_r;
                MODE_SINGLE: begin
                    if (match[1] && !done_r) pin_nxt = 1'b0;
                    else if (match[0] && !done_r) pin_nxt = 1'b1;
                end
                MODE_TRAIN: begin
                    if (match[1]) pin_nxt = 1'b0;
                    else if (match[0]) pin_nxt = 1'b1;
                end
                default: begin
                    if (rollover) pin_nxt = (prim_r != CMP_RST);
                    else if (match[0]) pin_nxt = 1'b0;
                    if (mode == MODE_PWMF && fault_act) pin_nxt = 1'b0;
                end
            endcase
        end
    end

    // output edge events that raise the interrupt
    always_comb begin
        edge_evt = 1'b0;
        if (!entry && !halt) begin
            unique case (mode)
                MODE_HIGH:   edge_evt = pin_nxt & ~pin_r;
                MODE_TOGGLE: edge_evt = pin_nxt ^ pin_r;
                MODE_LOW, MODE_SINGLE, MODE_TRAIN:
                    edge_evt = ~pin_nxt & pin_r;
                default:     edge_evt = 1'b0;
            endcase
        end
    end

    // status set terms, fault edge only in protected PWM
    assign stat_set[IRQ_EDGE]  = edge_evt;
    assign stat_set[IRQ_FAULT] = (mode == MODE_PWMF) && !halt && fault_fall;

    // pin, mode tracking and one-shot completion
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_r        <= 1'b0;
            mode_prev_r  <= MODE_OFF;
            done_r       <= 1'b0;
            fault_prev_r <= 1'b1;
        end else begin
            pin_r        <= pin_nxt;
            mode_prev_r  <= mode;
            fault_prev_r <= fault_s;
            if (entry) done_r <= 1'b0;
            else if (mode == MODE_SINGLE && match[1] && !halt) done_r <= 1'b1;
        end
    end
    assign compare_output_pin_o = pin_r;

    // fault flag, set wins, cleared by hardware outside mode 111
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) fault_flag_r <= 1'b0;
        else if (mode == MODE_PWMF && fault_act && !halt) fault_flag_r <= 1'b1;
        else if (mode != MODE_PWMF) fault_flag_r <= 1'b0;
    end

    // dma request pulse, only on the first two channels
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) dma_r <= 1'b0;
        else          dma_r <= DMA_OK && (|stat_set);
    end
    assign dma_req_o = dma_r;

    // write channel capture
    assign s_axi_awready_o = !aw_hold_r && !bvalid_r;
    assign s_axi_wready_o  = !w_hold_r && !bvalid_r;
    assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_hit = (awaddr_r == OFS_CTRL) || (awaddr_r == OFS_PRIM) ||
                    (awaddr_r == OFS_SEC) || (awaddr_r == OFS_STAT) ||
                    (awaddr_r == OFS_MASK);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= {s_axi_awaddr_i[ADDR_W-1:2], 2'h0};
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata_i;
                wstrb_r  <= s_axi_wstrb_i;
            end
            if (do_wr) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o  = bresp_r;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
    endfunction : merge16

    // configuration registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CTRL_RST;
            prim_r <= CMP_RST;
            sec_r  <= CMP_RST;
            mask_r <= IRQ_RST;
        end else if (do_wr) begin
            unique case (awaddr_r)
                OFS_CTRL: ctrl_r <= merge16(ctrl_r, wdata_r, wstrb_r) & CTRL_WMASK;
                OFS_PRIM: prim_r <= merge16(prim_r, wdata_r, wstrb_r);
                OFS_SEC:  sec_r  <= merge16(sec_r, wdata_r, wstrb_r);
                OFS_MASK: if (wstrb_r[0]) mask_r <= wdata_r[IRQ_W-1:0];
                default:  ;
            endcase
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_r <= IRQ_RST;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (stat_set[i]) stat_r[i] <= 1'b1;
                else if (do_wr && awaddr_r == OFS_STAT && wstrb_r[0] && wdata_r[i])
                    stat_r[i] <= 1'b0;
            end
        end
    end
    assign irq_o = |(stat_r & mask_r);

    // read channel
    assign ctrl_rd = {ctrl_r[15:5], fault_flag_r, ctrl_r[3:0]} & (CTRL_WMASK | 16'h0010);
    assign s_axi_arready_o = !rvalid_r;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid_i && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= '0;
            unique case ({s_axi_araddr_i[ADDR_W-1:2], 2'h0})
                OFS_CTRL: rdata_r[15:0] <= ctrl_rd;
                OFS_PRIM: rdata_r[CNT_W-1:0] <= prim_r;
                OFS_SEC:  rdata_r[CNT_W-1:0] <= sec_r;
                OFS_STAT: rdata_r[IRQ_W-1:0] <= stat_r;
                OFS_MASK: rdata_r[IRQ_W-1:0] <= mask_r;
                default:  rresp_r <= RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o  = rdata_r;
    assign s_axi_rresp_o  = rresp_r;

    // checks on the channel behaviour
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence pulse_start_s;
        mode == MODE_SINGLE && !entry && !halt && !done_r && match[0] && !match[1];
    endsequence
    sequence pulse_high_s;
        ##1 pin_r;
    endsequence

    tb_select_a: assert property (match[0] |-> (tb_sel ? second_time_base_i
                                   : first_time_base_i) == prim_r)
        else $error("time base select mismatch");
    disabled_quiet_a: assert property (mode == MODE_OFF |=> !stat_r[IRQ_EDGE] ||
                                       $past(stat_r[IRQ_EDGE]))
        else $error("disabled channel raised event");
    force_high_a: assert property (mode == MODE_HIGH && !entry && !halt
                                   && match[0] |=> pin_r ##1 stat_r[IRQ_EDGE] || !$past(pin_r, 2))
        else $error("high one-shot failed");
    force_low_a: assert property (mode == MODE_LOW && !entry && !halt
                                  && match[0] |=> !pin_r)
        else $error("low one-shot failed");
    toggle_pin_a: assert property (mode == MODE_TOGGLE && !entry && !halt
                                   && match[0] |=> pin_r != $past(pin_r))
        else $error("toggle missed");
    single_pulse_a: assert property (pulse_start_s |-> pulse_high_s)
        else $error("single pulse did not start");
    pwm_entry_a: assert property (entry && mode[2:1] == 2'b11
                                  |=> pin_r == (|prim_r && !(mode[0] && $past(fault_act))))
        else $error("pwm initial level wrong");
    fault_force_a: assert property (mode == MODE_PWMF && fault_act && !halt
                                    |=> !pin_r && fault_flag_r)
        else $error("fault did not force pin low");
    fault_clear_a: assert property (fault_flag_r && mode != MODE_PWMF
                                    |=> !fault_flag_r)
        else $error("fault flag not cleared");
    idle_hold_a: assert property (halt && !entry && mode != MODE_OFF
                                  |=> $stable(pin_r))
        else $error("pin moved while halted");
    dma_gate_a: assert property (dma_req_o |-> DMA_OK && $past(stat_set) != 2'h0)
        else $error("dma request from wrong channel");
    ctrl_zero_a: assert property (ctrl_r[15:14] == 2'h0 && ctrl_r[12:4] == 9'h000)
        else $error("unimplemented control bits set");
endmodule : occ_channel
`default_nettype wire

//--- rtl/occ_match.sv
// Purpose: compare one count against a set of compare values
// Assumes: count and values come from the same clock domain
// Notes:   a match is the first cycle of equality
`timescale 1ns/1ps
`default_nettype none
module occ_match #(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned N     = 2
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic [CNT_W-1:0] count_i,
    input  wire logic [CNT_W-1:0] cmp_i [N],
    output logic      [N-1:0]     match_o
);
    import occ_pkg::*;
    logic [N-1:0] eq;
    logic [N-1:0] eq_prev_r;
    // one comparator and edge flop per compare value
    for (genvar i = 0; i < N; i++) begin : g_cmp
        assign eq[i]      = (count_i == cmp_i[i]);
        assign match_o[i] = eq[i] & ~eq_prev_r[i];
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) eq_prev_r[i] <= 1'b0;
            else          eq_prev_r[i] <= eq[i];
        end
    end
endmodule : occ_match
`default_nettype wire

//--- rtl/occ_pkg.sv
// Purpose: shared constants of the output compare channel
// Assumes: 32-bit AXI4-Lite register window, 16-bit time bases
// Notes:   register offsets are byte addresses
package occ_pkg;
    // bus geometry
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 16;
    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_PRIM = 5'h04;
    localparam logic [4:0] OFS_SEC  = 5'h08;
    localparam logic [4:0] OFS_STAT = 5'h0C;
    localparam logic [4:0] OFS_MASK = 5'h10;
    // control field positions
    localparam int unsigned MODE_LSB   = 0;
    localparam int unsigned MODE_W     = 3;
    localparam int unsigned TBSEL_BIT  = 3;
    localparam int unsigned FAULT_BIT  = 4;
    localparam int unsigned IDLE_BIT   = 13;
    // writable control bits
    localparam logic [15:0] CTRL_WMASK = 16'h200F;
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CMP_RST  = 16'h0000;
    localparam logic [1:0]  IRQ_RST  = 2'h0;
    // interrupt status layout
    localparam int unsigned IRQ_W     = 2;
    localparam int unsigned IRQ_EDGE  = 0;
    localparam int unsigned IRQ_FAULT = 1;
    // mode codes
    localparam logic [2:0] MODE_OFF    = 3'h0;
    localparam logic [2:0] MODE_HIGH   = 3'h1;
    localparam logic [2:0] MODE_LOW    = 3'h2;
    localparam logic [2:0] MODE_TOGGLE = 3'h3;
    localparam logic [2:0] MODE_SINGLE = 3'h4;
    localparam logic [2:0] MODE_TRAIN  = 3'h5;
    localparam logic [2:0] MODE_PWM    = 3'h6;
    localparam logic [2:0] MODE_PWMF   = 3'h7;
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;
endpackage : occ_pkg

//--- rtl/occ_sync.sv
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: input is a slow level
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module occ_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output var  logic sync_o
);
    import occ_pkg::*;
    logic meta_r;
    // two flops, second one is the only reader of the first
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : occ_sync
`default_nettype wire

//--- testbench/occ_load_model.sv
// Purpose: load on the compare pin and source of the fault pin
// Assumes: fault line has a pull-up, released means high
// Notes:   counts pin edges between clears for the bench
`timescale 1ns/1ps
`default_nettype none
module occ_load_model (
    input  wire logic       clock_i,
    input  wire logic       pin_i,
    input  wire logic       clear_i,
    input  wire logic       fault_cmd_i,
    output logic            fault_n_o,
    output logic [7:0]      rises_o,
    output logic [7:0]      falls_o
);
    logic prev_r;
    // fault pulled low only on command, pull-up otherwise
    assign fault_n_o = fault_cmd_i ? 1'b0 : 1'b1;
    // edge counters on the driven pin
    always @(posedge clock_i) begin
        prev_r <= pin_i;
        if (clear_i) begin
            rises_o <= 8'h00;
            falls_o <= 8'h00;
        end else begin
            rises_o <= rises_o + 8'(pin_i === 1'b1 && prev_r === 1'b0);
            falls_o <= falls_o + 8'(pin_i === 1'b0 && prev_r === 1'b1);
        end
    end
endmodule : occ_load_model
`default_nettype wire

//--- testbench/test_occ_channel.sv
// Purpose: self-checking bench for the compare channel
// Assumes: bench timers of period 32 and 48 cycles
// Notes:   timers stop around every register write
`timescale 1ns/1ps
`default_nettype none
module test_occ_channel;
    import occ_pkg::*;
    logic clock_i, rst_n_i, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [15:0] t1, t2;
    logic roll1, roll2, run, idle, gpio, clr, fault_cmd, fault_n, pin, irq, dma;
    logic [7:0] rises, falls, dcnt;
    int failures, checks_done;
    occ_channel #(.CHAN_INDEX(1), .CNT_W(16)) occ_channel_inst (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1),
        .first_time_base_i(t1), .second_time_base_i(t2), .first_rollover_i(roll1),
        .second_rollover_i(roll2), .cpu_idle_i(idle), .gpio_level_i(gpio),
        .fault_input_pin_n_i(fault_n), .compare_output_pin_o(pin), .irq_o(irq),
        .dma_req_o(dma));
    occ_load_model occ_load_model_inst (.clock_i(clock_i), .pin_i(pin), .clear_i(clr),
        .fault_cmd_i(fault_cmd), .fault_n_o(fault_n), .rises_o(rises), .falls_o(falls));
    // clock of 5 ns
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // two time bases, cleared while stopped; dma pulse counter
    always @(posedge clock_i) begin
        t1 <= run ? ((t1 == 16'h001F) ? 16'h0000 : t1 + 16'h0001) : 16'h0000;
        t2 <= run ? ((t2 == 16'h002F) ? 16'h0000 : t2 + 16'h0001) : 16'h0000;
        roll1 <= run && (t1 == 16'h001E);
        roll2 <= run && (t2 == 16'h002E);
        dcnt <= clr ? 8'h00 : dcnt + 8'(dma === 1'b1);
    end
    task test_done;
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    task check_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask : check_val
    task check_resp(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
        end
    endtask : check_resp
    // write: address and data offered together, each released once taken
    task automatic axi_write(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clock_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge clock_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) return;
        end
        failures++;
        test_done();
    endtask : axi_write
    task automatic axi_read(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clock_i);
            ta = arvalid && arready;
            tr = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge clock_i);
            if (ta) arvalid <= 1'b0;
            if (tr) return;
        end
        failures++;
        test_done();
    endtask : axi_read
    // program with timers stopped, run 90 cycles, check edges and events
    task run_mode(input logic [15:0] c, input logic [15:0] p, input logic [15:0] s,
                  input logic [7:0] er, input logic [7:0] ef, input logic [7:0] ed);
        run <= 1'b0;
        @(posedge clock_i);
        axi_write(OFS_PRIM, {16'h0000, p}, r);
        axi_write(OFS_SEC, {16'h0000, s}, r);
        axi_write(OFS_STAT, 32'h0000_0003, r);
        axi_write(OFS_CTRL, {16'h0000, c}, r);
        clr <= 1'b1;
        repeat (2) @(posedge clock_i);
        clr <= 1'b0;
        run <= 1'b1;
        repeat (90) @(posedge clock_i);
        run <= 1'b0;
        repeat (3) @(posedge clock_i);
        check_val({24'h0, rises}, {24'h0, er});
        check_val({24'h0, falls}, {24'h0, ef});
        check_val({24'h0, dcnt}, {24'h0, ed});
        axi_read(OFS_STAT, d, r);
        check_val(d, {31'h0, ed != 8'h00});
        check_val({31'h0, irq}, {31'h0, ed != 8'h00});
    endtask : run_mode
    // main sequence
    initial begin
        {rst_n_i, awvalid, wvalid, arvalid, run, idle, gpio, fault_cmd} = 8'h00;
        {awaddr, araddr, wdata, clr} = '0;
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        axi_read(OFS_CTRL, d, r);
        check_val(d, 32'h0000_0000);
        axi_write(OFS_CTRL, 32'hFFFF_FFFF, r);
        check_resp(r, RESP_OKAY);
        axi_read(OFS_CTRL, d, r);
        check_val(d, 32'h0000_200F);
        axi_write(5'h14, 32'h0000_0001, r);
        check_resp(r, RESP_SLVERR);
        axi_read(5'h14, d, r);
        check_resp(r, RESP_SLVERR);
        axi_write(OFS_MASK, 32'h0000_0003, r);
        run_mode(16'h0000, 16'h0005, 16'h0000, 8'd0, 8'd0, 8'd0);
        gpio <= 1'b1;
        repeat (3) @(posedge clock_i);
        check_val({31'h0, pin}, 32'h1);
        gpio <= 1'b0;
        run_mode(16'h0001, 16'h0005, 16'h0000, 8'd1, 8'd0, 8'd1);
        run_mode(16'h0002, 16'h0005, 16'h0000, 8'd0, 8'd1, 8'd1);
        run_mode(16'h0003, 16'h0005, 16'h0000, 8'd2, 8'd1, 8'd3);
        run_mode(16'h0004, 16'h0005, 16'h000A, 8'd1, 8'd1, 8'd1);
        run_mode(16'h0005, 16'h0005, 16'h000A, 8'd3, 8'd3, 8'd3);
        run_mode(16'h0006, 16'h000A, 16'h0000, 8'd2, 8'd3, 8'd0);
        run_mode(16'h0007, 16'h000A, 16'h0000, 8'd2, 8'd3, 8'd0);
        run <= 1'b1;
        repeat (36) @(posedge clock_i);
        check_val({31'h0, pin}, 32'h1);
        fault_cmd <= 1'b1;
        repeat (6) @(posedge clock_i);
        check_val({31'h0, pin}, 32'h0);
        axi_read(OFS_CTRL, d, r);
        check_val(d, 32'h0000_0017);
        axi_read(OFS_STAT, d, r);
        check_val(d, 32'h0000_0002);
        check_val({31'h0, irq}, 32'h1);
        run <= 1'b0;
        fault_cmd <= 1'b0;
        axi_write(OFS_CTRL, 32'h0000_0000, r);
        axi_read(OFS_CTRL, d, r);
        check_val(d, 32'h0000_0000);
        run_mode(16'h0001, 16'h002D, 16'h0000, 8'd0, 8'd0, 8'd0);
        run_mode(16'h0009, 16'h002D, 16'h0000, 8'd1, 8'd0, 8'd1);
        idle <= 1'b1;
        run_mode(16'h0003, 16'h0005, 16'h0000, 8'd1, 8'd2, 8'd3);
        run_mode(16'h2003, 16'h0005, 16'h0000, 8'd0, 8'd0, 8'd0);
        test_done();
    end
endmodule : test_occ_channel
`default_nettype wire
